// ### hw/sas_consts.vh
// constants of the serial readout block
`ifndef SAS_CONSTS_VH
`define SAS_CONSTS_VH
`define SAS_RES_W        12
`define SAS_SYNC_W       3
`define SAS_FIFO_W       12
`define SAS_FIFO_D       4
`define SAS_FIFO_AW      2
`define SAS_SMPL_FALLS   2
`define SAS_NULL_BITS    1
`define SAS_RES_ZERO     12'h000
`define SAS_RES_MID      12'h800
`define SAS_RES_FULL     12'hFFF
`define SAS_BITCNT_W     5
`define SAS_BITS_FWD     5'd12
`define SAS_BITS_REV     5'd12
`endif

// ### hw/sas_fifo.v
// small fifo buffering conversion results
`timescale 1ns/1ps
`default_nettype none
module sas_fifo #(
  parameter W  = 12,
  parameter D  = 4,
  parameter AW = 2
) (
  // clock and reset
  input  wire          clk,
  input  wire          rstn,
  // write side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // read side
  output reg           out_valid,
  input  wire          out_ready,
  output reg  [W-1:0]  out_data
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0]   count;
  wire         do_wr;
  wire         do_rd;
  wire         take;

  assign in_ready = (count != D[AW:0]);
  assign do_wr    = in_valid && in_ready;
  // output register refills whenever empty or being drained
  assign take     = !out_valid || out_ready;
  assign do_rd    = take && (count != {(AW+1){1'b0}});

  always @(posedge clk) begin
    if (do_wr) begin
      mem[wptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr      <= {AW{1'b0}};
      rptr      <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {W{1'b0}};
    end else begin
      if (do_wr) begin
        wptr <= wptr + 1'b1;
      end
      if (do_rd) begin
        rptr     <= rptr + 1'b1;
        out_data <= mem[rptr];
      end
      if (take) begin
        out_valid <= do_rd;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (!do_wr && do_rd) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sas_fifo
`default_nettype wire

// ### hw/sas_readout.v
// converter sequencing and serial result readout
`timescale 1ns/1ps
`default_nettype none
`include "sas_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// (R1) select falling starts conversion and transfer
// (R2) first 1.5 to 2 clocks acquire input
// (R3) after second falling edge, one zero bit
// (R4) next twelve bits: result, msb first
// (R5) then result repeated, lsb first
// (R6) after repeated msb, output goes tri-state
// (R7) later clock edges change nothing
// (R8) new conversion needs select high then low
// (R9) output changes on bit clock falling edge
// (R10) host samples on rising edge normally
// (R11) result is plain unsigned binary code
// (R12) host keeps average rate at most 75kHz
// (R13) power down at completion or select high
// (R14) completion idles analog only; select high all
// (R15) host advised fastest clock, then idle high
// (R16) host advised not to leave select low
// (R17) raising select early aborts and powers down
// (R18) select high: output tri-state, clocks ignored
module sas_readout (
  // clock and reset
  input  wire                   CLOCK,
  input  wire                   RSTN,
  // serial link pins
  input  wire                   FRAME_SELECT_N,
  input  wire                   SERIAL_BIT_CLOCK,
  output reg                    SERIAL_DATA_OUT,
  output reg                    SERIAL_DATA_OE_N,
  // result from the approximation core
  input  wire [`SAS_RES_W-1:0]  RESULT_IN,
  // sampling and power controls to the analog and digital sections
  output reg                    SAMPLE_ACTIVE,
  output reg                    ANALOG_POWER_DOWN,
  output reg                    DIGITAL_POWER_DOWN,
  // stream of completed results
  output reg                    RESULT_VALID,
  input  wire                   RESULT_READY,
  output reg  [`SAS_RES_W-1:0]  RESULT_DATA,
  output reg                    RESULT_DROPPED
);

  //////////////////////////////////////////////////////////////////////////////
  // states, one-hot
  localparam [5:0] ST_IDLE = 6'b00_0001;
  localparam [5:0] ST_SMPL = 6'b00_0010;
  localparam [5:0] ST_NULL = 6'b00_0100;
  localparam [5:0] ST_FWD  = 6'b00_1000;
  localparam [5:0] ST_REV  = 6'b01_0000;
  localparam [5:0] ST_DONE = 6'b10_0000;

  // bit of the result for a given send position
  function sel_bit;
    input [`SAS_RES_W-1:0]   word;
    input [`SAS_BITCNT_W-1:0] idx;
    begin
      sel_bit = word[idx[3:0]];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change counts once stages two and three agree
  // a lone sample between the two never moves the filtered level
  reg [`SAS_SYNC_W-1:0] cs_sync;
  reg [`SAS_SYNC_W-1:0] ck_sync;
  reg                   cs_n;
  reg                   bclk;

  // frame select rests high, so reset matches the idle pin
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cs_sync <= {`SAS_SYNC_W{1'b1}};
      cs_n    <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[`SAS_SYNC_W-2:0], FRAME_SELECT_N};
      if (cs_sync[1] == cs_sync[2]) begin
        cs_n <= cs_sync[2];
      end
    end
  end

  // bit clock rests low, so reset matches the idle pin
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ck_sync <= {`SAS_SYNC_W{1'b0}};
      bclk    <= 1'b0;
    end else begin
      ck_sync <= {ck_sync[`SAS_SYNC_W-2:0], SERIAL_BIT_CLOCK};
      if (ck_sync[1] == ck_sync[2]) begin
        bclk <= ck_sync[2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge detectors on the filtered levels
  reg  cs_n_d;
  reg  bclk_d;
  wire cs_fall;
  wire clk_fall;

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cs_n_d <= 1'b1;
    end else begin
      cs_n_d <= cs_n;
    end
  end

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      bclk_d <= 1'b0;
    end else begin
      bclk_d <= bclk;
    end
  end

  // a frame opens only on a true high-to-low edge of select
  assign cs_fall  = cs_n_d && !cs_n;  // [R1] [R8]
  assign clk_fall = bclk_d && !bclk;  // [R9]

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  reg [5:0]                state;
  reg [5:0]                next_state;
  reg [`SAS_BITCNT_W-1:0]  cnt;
  reg [`SAS_BITCNT_W-1:0]  next_cnt;
  reg [`SAS_RES_W-1:0]     result;
  reg                      push;

  always @* begin
    next_state = state;
    next_cnt   = cnt;
    push       = 1'b0;
    // select high wins over every state: abort, release, power down
    if (cs_n) begin
      next_state = ST_IDLE;                      // [R17] [R18]
      next_cnt   = {`SAS_BITCNT_W{1'b0}};
    end else begin
      case (state)
        ST_IDLE: begin
          if (cs_fall) begin
            next_state = ST_SMPL;                // [R1]
            next_cnt   = {`SAS_BITCNT_W{1'b0}};
          end
        end
        ST_SMPL: begin
          // acquisition spans the falls before the null bit
          if (clk_fall) begin
            if (cnt == `SAS_SMPL_FALLS - 1) begin
              next_state = ST_NULL;              // [R2] [R3]
              next_cnt   = {`SAS_BITCNT_W{1'b0}};
            end else begin
              next_cnt = cnt + 1'b1;
            end
          end
        end
        ST_NULL: begin
          // leading zero lasts one bit clock
          if (clk_fall) begin
            next_state = ST_FWD;                 // [R4]
            next_cnt   = `SAS_BITS_FWD - 1'b1;
          end
        end
        ST_FWD: begin
          if (clk_fall) begin
            if (cnt == {`SAS_BITCNT_W{1'b0}}) begin
              // lsb sent once; repeat starts again at lsb
              next_state = ST_REV;               // [R5]
              next_cnt   = {`SAS_BITCNT_W{1'b0}};
              push       = 1'b1;
            end else begin
              next_cnt = cnt - 1'b1;
            end
          end
        end
        ST_REV: begin
          if (clk_fall) begin
            if (cnt == `SAS_BITS_REV - 1'b1) begin
              next_state = ST_DONE;              // [R6]
            end else begin
              next_cnt = cnt + 1'b1;
            end
          end
        end
        ST_DONE: begin
          // frame spent: only a select rise leaves this state
          next_state = ST_DONE;                  // [R7]
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_IDLE;
      cnt   <= {`SAS_BITCNT_W{1'b0}};
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // held after sampling: straight binary, no recoding; the core may move
  // on afterwards, both passes still send this one word
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      result <= `SAS_RES_ZERO;
    end else begin
      if (state == ST_SMPL && next_state == ST_NULL) begin
        result <= RESULT_IN;                     // [R11]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial pin outputs, all registered; decoded from the coming state so
  // the pin moves in the same cycle as the state
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      SERIAL_DATA_OUT  <= 1'b0;
      SERIAL_DATA_OE_N <= 1'b1;
    end else begin
      case (next_state)
        ST_NULL: begin
          SERIAL_DATA_OUT  <= 1'b0;              // [R3]
          SERIAL_DATA_OE_N <= 1'b0;
        end
        ST_FWD: begin
          SERIAL_DATA_OUT  <= sel_bit(result, next_cnt); // [R4]
          SERIAL_DATA_OE_N <= 1'b0;
        end
        ST_REV: begin
          SERIAL_DATA_OUT  <= sel_bit(result, next_cnt); // [R5]
          SERIAL_DATA_OE_N <= 1'b0;
        end
        ST_DONE: begin
          // frame spent: pin released until select rises
          SERIAL_DATA_OUT  <= 1'b0;
          SERIAL_DATA_OE_N <= 1'b1;              // [R6] [R7]
        end
        default: begin
          // idle or acquiring: nothing on the pin yet
          SERIAL_DATA_OUT  <= 1'b0;
          SERIAL_DATA_OE_N <= 1'b1;              // [R2] [R18]
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // acquisition and analog power; the array is only charged while sampling
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      SAMPLE_ACTIVE     <= 1'b0;
      ANALOG_POWER_DOWN <= 1'b1;
    end else begin
      case (next_state)
        ST_SMPL: begin
          SAMPLE_ACTIVE     <= 1'b1;             // [R2]
          ANALOG_POWER_DOWN <= 1'b0;
        end
        ST_NULL, ST_FWD, ST_REV: begin
          SAMPLE_ACTIVE     <= 1'b0;
          ANALOG_POWER_DOWN <= 1'b0;
        end
        default: begin
          // idle or done: comparator and array off
          SAMPLE_ACTIVE     <= 1'b0;
          ANALOG_POWER_DOWN <= 1'b1;             // [R13] [R14]
        end
      endcase
    end
  end

  // digital section sleeps only on select high, never on completion
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      DIGITAL_POWER_DOWN <= 1'b1;
    end else begin
      DIGITAL_POWER_DOWN <= cs_n;                // [R14]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // completed results into the fifo; a full fifo drops, never stalls the pins
  wire                  fifo_in_ready;
  wire                  fifo_out_valid;
  wire [`SAS_RES_W-1:0] fifo_out_data;
  reg                   fifo_out_ready;

  sas_fifo #(
    .W  (`SAS_FIFO_W),
    .D  (`SAS_FIFO_D),
    .AW (`SAS_FIFO_AW)
  ) u_fifo (
    .clk       (CLOCK),
    .rstn      (RSTN),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (result),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // registered skid: take a word when output slot is free
  always @* begin
    fifo_out_ready = !RESULT_VALID || RESULT_READY;
  end

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RESULT_VALID <= 1'b0;
      RESULT_DATA  <= `SAS_RES_ZERO;
    end else begin
      if (fifo_out_ready) begin
        RESULT_VALID <= fifo_out_valid;
        if (fifo_out_valid) begin
          RESULT_DATA <= fifo_out_data;
        end
      end
    end
  end

  // loss flag: one pulse per word that found the buffer full; a slow
  // reader loses the newest results and keeps the oldest
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RESULT_DROPPED <= 1'b0;
    end else begin
      RESULT_DROPPED <= push && !fifo_in_ready;
    end
  end

endmodule // sas_readout
`default_nettype wire

// ### test/sas_host.sv
// host model driving select and bit clock
`timescale 1ns/1ps
`default_nettype none
module sas_host (
  input  wire logic clk,
  output var  logic sel_n,
  output var  logic bclk,
  input  wire logic dout,
  input  wire logic oe_n
);
  logic [31:0] bits;
  logic [31:0] oes;
  // bit clock rests low between frames
  initial begin
    sel_n = 1'b1;
    bclk  = 1'b0;
    bits  = '0;
    oes   = '0;
  end
  // bit clock 8 cycles high and 8 low, then select high with the clock idle low
  task automatic frame(input int falls);
    sel_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int k = 0; k <= falls; k++) begin
      bits[k] = dout; // sampled where the clock rises
      oes[k]  = oe_n;
      if (k == falls) break;
      bclk <= 1'b1;
      repeat (8) @(posedge clk);
      bclk <= 1'b0;
      repeat (8) @(posedge clk);
    end
    sel_n <= 1'b1;
    // a short frame idles longer, so every frame spans 480 cycles
    repeat (24 + 16 * (28 - falls)) @(posedge clk);
  endtask
endmodule // sas_host
`default_nettype wire

// ### test/sas_readout_properties.sv
// checker for the serial readout block
`timescale 1ns/1ps
`default_nettype none
`include "sas_consts.vh"
module sas_readout_props (
  // clock and reset
  input wire logic                  CLOCK,
  input wire logic                  RSTN,
  // serial link
  input wire logic                  FRAME_SELECT_N,
  input wire logic                  SERIAL_BIT_CLOCK,
  input wire logic                  SERIAL_DATA_OUT,
  input wire logic                  SERIAL_DATA_OE_N,
  // power and sampling
  input wire logic                  SAMPLE_ACTIVE,
  input wire logic                  ANALOG_POWER_DOWN,
  input wire logic                  DIGITAL_POWER_DOWN,
  // result stream
  input wire logic                  RESULT_VALID,
  input wire logic                  RESULT_READY,
  input wire logic [`SAS_RES_W-1:0] RESULT_DATA
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // eight cycles covers the pin synchronisers and output register
  sequence sel_high; FRAME_SELECT_N [*8]; endsequence
  sequence sel_low; !FRAME_SELECT_N [*8]; endsequence
  sequence quiet; ($stable(SERIAL_BIT_CLOCK) && $stable(FRAME_SELECT_N)) [*7]; endsequence
  AST_OE_SEL: assert property (sel_high |-> SERIAL_DATA_OE_N)
    else $error("output driven with select high");
  AST_FULL_PD: assert property (sel_high |-> DIGITAL_POWER_DOWN && ANALOG_POWER_DOWN)
    else $error("not fully powered down with select high");
  AST_DIG_ON: assert property (sel_low |-> !DIGITAL_POWER_DOWN)
    else $error("digital section down with select low");
  AST_QUIET: assert property (quiet |=> $stable(SERIAL_DATA_OUT) && $stable(SERIAL_DATA_OE_N))
    else $error("serial output moved without a bit clock fall");
  AST_SAMPLE: assert property ($fell(FRAME_SELECT_N) |-> ##[2:8] SAMPLE_ACTIVE)
    else $error("select fall did not start acquisition");
  AST_ZERO_BIT: assert property ($fell(SERIAL_DATA_OE_N) |-> !SERIAL_DATA_OUT)
    else $error("first driven bit not zero");
  AST_DONE_PD: assert property ($rose(SERIAL_DATA_OE_N) && !FRAME_SELECT_N
    |-> ##[0:2] (ANALOG_POWER_DOWN && !DIGITAL_POWER_DOWN))
    else $error("wrong power state after completion");
  AST_HOLD: assert property (RESULT_VALID && !RESULT_READY |=> RESULT_VALID && $stable(RESULT_DATA))
    else $error("result dropped before acceptance");
endmodule // sas_readout_props
////////////////////////////////////////////////////////////////////////////////
bind sas_readout sas_readout_props u_props (
  .CLOCK(CLOCK), .RSTN(RSTN), .FRAME_SELECT_N(FRAME_SELECT_N),
  .SERIAL_BIT_CLOCK(SERIAL_BIT_CLOCK), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
  .SERIAL_DATA_OE_N(SERIAL_DATA_OE_N), .SAMPLE_ACTIVE(SAMPLE_ACTIVE),
  .ANALOG_POWER_DOWN(ANALOG_POWER_DOWN), .DIGITAL_POWER_DOWN(DIGITAL_POWER_DOWN),
  .RESULT_VALID(RESULT_VALID), .RESULT_READY(RESULT_READY), .RESULT_DATA(RESULT_DATA));
`default_nettype wire

// ### test/tb_sar_adc_serial_readout.sv
// testbench of the serial readout block
`timescale 1ns/1ps
`default_nettype none
`include "sas_consts.vh"
module tb_sar_adc_serial_readout;
  logic        CLOCK;
  logic        RSTN;
  logic [11:0] RESULT_IN;
  logic        RESULT_READY;
  wire         sel_n, bclk, dout, oe_n, valid, dropped;
  wire  [11:0] rdata;
  int          bad_count = 0;
  int          n_tests = 0;
  int          drops = 0;
  logic [11:0] codes [7] = '{12'h000, 12'h800, 12'hFFF, 12'h7FF, 12'hA5C, 12'h001, 12'h3FE};
  sas_host h (.clk(CLOCK), .sel_n(sel_n), .bclk(bclk), .dout(dout), .oe_n(oe_n));
  sas_readout dut (
    .CLOCK(CLOCK), .RSTN(RSTN), .FRAME_SELECT_N(sel_n), .SERIAL_BIT_CLOCK(bclk),
    .SERIAL_DATA_OUT(dout), .SERIAL_DATA_OE_N(oe_n), .RESULT_IN(RESULT_IN),
    .SAMPLE_ACTIVE(), .ANALOG_POWER_DOWN(), .DIGITAL_POWER_DOWN(),
    .RESULT_VALID(valid), .RESULT_READY(RESULT_READY), .RESULT_DATA(rdata),
    .RESULT_DROPPED(dropped));
  always #25 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (dropped === 1'b1) drops++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // frame of given length, checks enable and every driven bit
  task automatic run_frame(input logic [11:0] c, input int falls);
    logic e;
    RESULT_IN <= c;
    h.frame(falls);
    for (int i = 0; i <= falls; i++) begin
      e = (i < 2 || i > 26);
      check("oe_n", {11'h0, h.oes[i]}, {11'h0, e});
      if (!e) check("bit", {11'h0, h.bits[i]},
        {11'h0, (i < 3) ? 1'b0 : (i <= 14) ? c[14-i] : c[i-15]});
    end
  endtask
  task automatic drain(input logic [11:0] e);
    int n = 0;
    while (valid !== 1'b1 && n < 50) begin
      @(posedge CLOCK);
      n++;
    end
    check("result", rdata, e);
    RESULT_READY <= 1'b1;
    @(posedge CLOCK);
    RESULT_READY <= 1'b0;
    @(posedge CLOCK);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge CLOCK);
    bad_count++;
    conclude();
  end
  initial begin
    CLOCK = 1'b0;
    RSTN = 1'b0;
    RESULT_IN = 12'h000;
    RESULT_READY = 1'b0;
    repeat (4) @(posedge CLOCK);
    RSTN <= 1'b1;
    repeat (6) @(posedge CLOCK);
    check("idle oe_n", {11'h0, oe_n}, 12'h001);
    // seven full frames: four buffered words plus the two output
    // registers hold six, so only the last one is lost
    foreach (codes[i]) run_frame(codes[i], 28);
    check("drops", 12'(drops), 12'h001);
    foreach (codes[i]) if (i < 6) drain(codes[i]);
    $display("test full frames done");
    // short cycle after eight result bits
    run_frame(12'h3C3, 10);
    check("abort oe_n", {11'h0, oe_n}, 12'h001);
    check("abort push", {11'h0, valid}, 12'h000);
    run_frame(12'h5A1, 28);
    drain(12'h5A1);
    $display("test abort done");
    conclude();
  end
endmodule // tb_sar_adc_serial_readout
`default_nettype wire
